//--- hdl/sfd_pkg.sv
/*
 * Shared constants and carrier types for the service and set-features decoder.
 * Assumes a single 250 MHz system clock and a same-clock task-file register port.
 */
package sfd_pkg;
	// ==========================================================
	// Register offsets on the task-file port
	localparam logic [3:0] OFF_CONTROL = 4'h0;
	localparam logic [3:0] OFF_FEAT_ERR = 4'h1;
	localparam logic [3:0] OFF_COUNT = 4'h2;
	localparam logic [3:0] OFF_NUMBER = 4'h3;
	localparam logic [3:0] OFF_CYL_LO = 4'h4;
	localparam logic [3:0] OFF_CYL_HI = 4'h5;
	localparam logic [3:0] OFF_DEVHEAD = 4'h6;
	localparam logic [3:0] OFF_CMD_STAT = 4'h7;

	// ==========================================================
	// Opcodes and subcommand codes
	localparam logic [7:0] OP_SERVICE = 8'ha2;
	localparam logic [7:0] OP_SET_FEATURES = 8'hef;
	localparam logic [7:0] SUB_BYTE_PIO_ON = 8'h01;
	localparam logic [7:0] SUB_BYTE_PIO_OFF = 8'h81;
	localparam logic [7:0] SUB_WCACHE_ON = 8'h02;
	localparam logic [7:0] SUB_WCACHE_OFF = 8'h82;
	localparam logic [7:0] SUB_XFER_MODE = 8'h03;
	localparam logic [7:0] SUB_APM_ON = 8'h05;
	localparam logic [7:0] SUB_APM_OFF = 8'h85;
	localparam logic [7:0] SUB_PUIS_ON = 8'h06;
	localparam logic [7:0] SUB_PUIS_OFF = 8'h86;
	localparam logic [7:0] SUB_SPIN_UP = 8'h07;
	localparam logic [7:0] SUB_HIPWR_ON = 8'h0a;
	localparam logic [7:0] SUB_HIPWR_OFF = 8'h8a;
	localparam logic [7:0] SUB_MSN_OFF = 8'h31;
	localparam logic [7:0] SUB_MSN_ON = 8'h95;
	localparam logic [7:0] SUB_AAM_ON = 8'h42;
	localparam logic [7:0] SUB_AAM_OFF = 8'hc2;
	localparam logic [7:0] SUB_LOOKAHEAD_OFF = 8'h55;
	localparam logic [7:0] SUB_LOOKAHEAD_ON = 8'haa;
	localparam logic [7:0] SUB_KEEP_SETTINGS = 8'h66;
	localparam logic [7:0] SUB_REVERT_SETTINGS = 8'hcc;

	// ==========================================================
	// Field positions and values
	localparam int BIT_BUSY = 7;
	localparam int BIT_READY = 6;
	localparam int BIT_FAULT = 5;
	localparam int BIT_SERVICE_REQUEST_FLAG = 4;
	localparam int BIT_DRQ = 3;
	localparam int BIT_ERR = 0;
	localparam int BIT_ABORT = 2;
	localparam int BIT_DRIVE_SEL = 4;
	localparam int BIT_CTRL_SRST = 2;
	localparam logic [4:0] XFER_PIO_DEFAULT = 5'h00;
	localparam logic [4:0] XFER_PIO_FLOW = 5'h01;
	localparam logic [4:0] XFER_MWDMA = 5'h04;
	localparam logic [4:0] XFER_UDMA = 5'h08;
	localparam logic [2:0] PIO_DEFAULT_IORDY_OFF = 3'h1;
	localparam logic [7:0] APM_LEVEL_LOW_BAD = 8'h00;
	localparam logic [7:0] APM_LEVEL_HIGH_BAD = 8'hff;
	localparam logic [7:0] ARG_RESET = 8'h01;

	// ==========================================================
	// Types
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sfd_bus_req_type;

	typedef struct packed {
		logic byte_pio;
		logic write_cache;
		logic [7:0] xfer_mode;
		logic apm_en;
		logic [7:0] apm_level;
		logic puis_en;
		logic high_power;
		logic aam_en;
		logic [7:0] aam_level;
		logic look_ahead;
		logic keep_settings;
		logic msn_en;
	} sfd_settings_type;

	// Power-on defaults of every feature setting
	localparam sfd_settings_type SETTINGS_DEFAULT = '{
		byte_pio: 1'b0, write_cache: 1'b1, xfer_mode: 8'h00, apm_en: 1'b0, apm_level: 8'hfe,
		puis_en: 1'b0, high_power: 1'b1, aam_en: 1'b0, aam_level: 8'hfe, look_ahead: 1'b1,
		keep_settings: 1'b0, msn_en: 1'b0};

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_DONE = 3'b100
	} sfd_state_type;
endpackage : sfd_pkg

//--- hdl/sfd_decoder.sv
/*
 * Task-file decoder for the service and set-features commands, with the feature
 * settings they control. Assumes the register master and the device core run on
 * clk_sys; release_req, fault and action_fail come from same-clock core logic.
 */
// The register addresses and the address-and-strobe port were decided locally.
// Functional notes
// R1 - Opcode a2h resumes transfer or status of a previously bus-released command.
// R2 - Service allowed only after bus release with the service request flag set.
// R3 - Service leaves the serviced command's register outputs untouched; the code still updates the status bits in ST_DONE.
// R4 - Drive select bit 4 picks the addressed device; it stays visible.
// R5 - Opcode efh runs set-features as a non-data command.
// R6 - Subcode comes from feature register; arguments from count, number, cylinder; the code latches only count.
// R7 - Unsupported or invalid subcode or argument aborts with error bit 2.
// R8 - Abort may also flag an action the device cannot carry out.
// R9 - Completion clears busy and data request, sets ready, fault, error summary.
// R10 - Host issues set-features only while device ready reads one.
// R11 - Power-on and hardware reset load default settings.
// R12 - Subcode 03h sets transfer mode from the count register.
// R13 - With write cache, 02h enables and 82h disables it.
// R14 - With removable media, 95h enables and 31h disables status notification.
// R15 - 01h and 81h toggle byte-wide transfers on devices with that option.
// R16 - 05h enables and 85h disables advanced power management.
// R17 - 06h/86h toggle power-up in standby; 07h spins the device up.
// R18 - 0ah enables and 8ah disables the higher power mode.
// R19 - 42h enables and c2h disables automatic acoustic management.
// R20 - 55h disables and aah enables read look-ahead.
// R21 - 66h keeps settings over soft reset; cch restores reverting.
// R22 - Reserved, obsolete and unlisted codes are treated as unsupported.
// R23 - Subcode and arguments are sampled at command write; busy holds until done.
module sfd_decoder #(
	parameter logic DEVICE_SELECT = 1'b0,
	parameter logic HAS_WCACHE = 1'b1,
	parameter logic HAS_REMOVABLE = 1'b0,
	parameter logic HAS_BYTE_PIO = 1'b0,
	parameter logic [2:0] MAX_PIO = 3'h4,
	parameter logic [2:0] MAX_MWDMA = 3'h2,
	parameter logic [2:0] MAX_UDMA = 3'h5
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire sfd_pkg::sfd_bus_req_type bus_req,
	output logic [7:0] rd_data,
	input wire logic release_req,
	input wire logic fault,
	input wire logic action_fail,
	output sfd_pkg::sfd_settings_type settings,
	output logic service_go,
	output logic spin_up_go
);
	// ==========================================================
	// State
	typedef struct packed {
		sfd_pkg::sfd_state_type st;
		logic [7:0] feat;
		logic [7:0] count;
		logic [7:0] number;
		logic [7:0] cyl_lo;
		logic [7:0] cyl_hi;
		logic [7:0] devhead;
		logic [7:0] lat_op;
		logic [7:0] lat_sub;
		logic [7:0] lat_count;
		logic [7:0] err;
		logic busy_flag;
		logic device_ready_flag;
		logic df;
		logic service_request_flag;
		logic data_request_flag;
		sfd_pkg::sfd_settings_type set;
		logic [7:0] rd_data;
		logic service_go;
		logic spin_up_go;
	} sfd_regs_type;

	localparam sfd_regs_type REGS_RESET = '{
		st: sfd_pkg::ST_IDLE, feat: 8'h00, count: sfd_pkg::ARG_RESET, number: sfd_pkg::ARG_RESET,
		cyl_lo: 8'h00, cyl_hi: 8'h00,
		devhead: 8'h00, lat_op: 8'h00, lat_sub: 8'h00, lat_count: 8'h00, err: 8'h00, busy_flag: 1'b0,
		device_ready_flag: 1'b1, df: 1'b0, service_request_flag: 1'b0, data_request_flag: 1'b0, set: sfd_pkg::SETTINGS_DEFAULT,
		rd_data: 8'h00, service_go: 1'b0, spin_up_go: 1'b0};

	sfd_regs_type s;
	sfd_regs_type next_s;
	logic sub_ok;
	logic cmd_write;
	logic cmd_accept;

	// ==========================================================
	// Helpers
	function automatic logic mode_valid(input logic [7:0] v);
		logic ok;
		ok = 1'b0;
		case (v[7:3])
			sfd_pkg::XFER_PIO_DEFAULT: ok = (v[2:0] <= sfd_pkg::PIO_DEFAULT_IORDY_OFF);
			sfd_pkg::XFER_PIO_FLOW: ok = (v[2:0] <= MAX_PIO);
			sfd_pkg::XFER_MWDMA: ok = (v[2:0] <= MAX_MWDMA);
			sfd_pkg::XFER_UDMA: ok = (v[2:0] <= MAX_UDMA);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : mode_valid

	function automatic logic [7:0] status_byte(input sfd_regs_type r);
		logic [7:0] b;
		b = 8'h00;
		b[sfd_pkg::BIT_BUSY] = r.busy_flag;
		b[sfd_pkg::BIT_READY] = r.device_ready_flag;
		b[sfd_pkg::BIT_FAULT] = r.df;
		b[sfd_pkg::BIT_SERVICE_REQUEST_FLAG] = r.service_request_flag;
		b[sfd_pkg::BIT_DRQ] = r.data_request_flag;
		b[sfd_pkg::BIT_ERR] = (r.err != 8'h00);
		return b;
	endfunction : status_byte

	// Support check of the latched subcommand and its argument
	always_comb begin
		sub_ok = 1'b0;
		case (s.lat_sub)
			sfd_pkg::SUB_XFER_MODE: sub_ok = mode_valid(s.lat_count); // R12
			sfd_pkg::SUB_WCACHE_ON, sfd_pkg::SUB_WCACHE_OFF: sub_ok = HAS_WCACHE; // R13
			sfd_pkg::SUB_MSN_ON, sfd_pkg::SUB_MSN_OFF: sub_ok = HAS_REMOVABLE; // R14
			sfd_pkg::SUB_BYTE_PIO_ON, sfd_pkg::SUB_BYTE_PIO_OFF: sub_ok = HAS_BYTE_PIO; // R15
			sfd_pkg::SUB_APM_ON: sub_ok = (s.lat_count != sfd_pkg::APM_LEVEL_LOW_BAD) &&
				(s.lat_count != sfd_pkg::APM_LEVEL_HIGH_BAD); // R16
			sfd_pkg::SUB_APM_OFF, sfd_pkg::SUB_PUIS_ON, sfd_pkg::SUB_PUIS_OFF: sub_ok = 1'b1;
			sfd_pkg::SUB_SPIN_UP: sub_ok = 1'b1; // R17
			sfd_pkg::SUB_HIPWR_ON, sfd_pkg::SUB_HIPWR_OFF: sub_ok = 1'b1; // R18
			sfd_pkg::SUB_AAM_ON, sfd_pkg::SUB_AAM_OFF: sub_ok = 1'b1; // R19
			sfd_pkg::SUB_LOOKAHEAD_ON, sfd_pkg::SUB_LOOKAHEAD_OFF: sub_ok = 1'b1; // R20
			sfd_pkg::SUB_KEEP_SETTINGS, sfd_pkg::SUB_REVERT_SETTINGS: sub_ok = 1'b1; // R21
			default: sub_ok = 1'b0; // R22
		endcase
	end

	assign cmd_write = bus_req.wr && (bus_req.addr == sfd_pkg::OFF_CMD_STAT);
	// Commands for the other drive, or arriving while busy, are dropped silently
	assign cmd_accept = cmd_write && !s.busy_flag &&
		(s.devhead[sfd_pkg::BIT_DRIVE_SEL] == DEVICE_SELECT) && // R4
		((bus_req.wdata == sfd_pkg::OP_SET_FEATURES) || (bus_req.wdata == sfd_pkg::OP_SERVICE)); // R1 R5

	// ==========================================================
	// Next state
	always_comb begin
		next_s = s;
		next_s.service_go = 1'b0;
		next_s.spin_up_go = 1'b0;
		next_s.rd_data = 8'h00;

		// Register reads, data valid in the following cycle
		if (bus_req.rd) begin
			case (bus_req.addr)
				sfd_pkg::OFF_FEAT_ERR: next_s.rd_data = s.err;
				sfd_pkg::OFF_COUNT: next_s.rd_data = s.count;
				sfd_pkg::OFF_NUMBER: next_s.rd_data = s.number;
				sfd_pkg::OFF_CYL_LO: next_s.rd_data = s.cyl_lo;
				sfd_pkg::OFF_CYL_HI: next_s.rd_data = s.cyl_hi;
				sfd_pkg::OFF_DEVHEAD: next_s.rd_data = s.devhead; // R4
				sfd_pkg::OFF_CMD_STAT: next_s.rd_data = status_byte(s); // R9
				default: next_s.rd_data = 8'h00;
			endcase
		end

		// Task-file writes other than the control register are ignored while busy so latched arguments stay stable
		if (bus_req.wr && !s.busy_flag) begin
			case (bus_req.addr)
				sfd_pkg::OFF_FEAT_ERR: next_s.feat = bus_req.wdata;
				sfd_pkg::OFF_COUNT: next_s.count = bus_req.wdata;
				sfd_pkg::OFF_NUMBER: next_s.number = bus_req.wdata;
				sfd_pkg::OFF_CYL_LO: next_s.cyl_lo = bus_req.wdata;
				sfd_pkg::OFF_CYL_HI: next_s.cyl_hi = bus_req.wdata;
				sfd_pkg::OFF_DEVHEAD: next_s.devhead = bus_req.wdata;
				default: ;
			endcase
		end

		if (cmd_accept) begin
			next_s.lat_op = bus_req.wdata;
			next_s.lat_sub = s.feat; // R6 R23
			next_s.lat_count = s.count; // R6 R23
			next_s.busy_flag = 1'b1; // R23
			next_s.st = sfd_pkg::ST_EXEC;
		end

		case (s.st)
			sfd_pkg::ST_IDLE: ;
			sfd_pkg::ST_EXEC: begin
				if (s.lat_op == sfd_pkg::OP_SERVICE) begin
					if (s.service_request_flag) begin
						// Serviced command takes over the transfer; ST_DONE still drives busy, ready, data request and fault
						next_s.service_go = 1'b1; // R1 R3
						next_s.service_request_flag = 1'b0; // R2
					end else begin
						next_s.err = 8'h00;
						next_s.err[sfd_pkg::BIT_ABORT] = 1'b1; // R2
					end
				end else begin
					next_s.err = 8'h00;
					if (!sub_ok || action_fail) begin
						next_s.err[sfd_pkg::BIT_ABORT] = 1'b1; // R7 R8
					end else begin
						case (s.lat_sub)
							sfd_pkg::SUB_XFER_MODE: next_s.set.xfer_mode = s.lat_count; // R12
							sfd_pkg::SUB_WCACHE_ON: next_s.set.write_cache = 1'b1; // R13
							sfd_pkg::SUB_WCACHE_OFF: next_s.set.write_cache = 1'b0; // R13
							sfd_pkg::SUB_MSN_ON: next_s.set.msn_en = 1'b1; // R14
							sfd_pkg::SUB_MSN_OFF: next_s.set.msn_en = 1'b0; // R14
							sfd_pkg::SUB_BYTE_PIO_ON: next_s.set.byte_pio = 1'b1; // R15
							sfd_pkg::SUB_BYTE_PIO_OFF: next_s.set.byte_pio = 1'b0; // R15
							sfd_pkg::SUB_APM_ON: begin
								next_s.set.apm_en = 1'b1; // R16
								next_s.set.apm_level = s.lat_count;
							end
							sfd_pkg::SUB_APM_OFF: next_s.set.apm_en = 1'b0; // R16
							sfd_pkg::SUB_PUIS_ON: next_s.set.puis_en = 1'b1; // R17
							sfd_pkg::SUB_PUIS_OFF: next_s.set.puis_en = 1'b0; // R17
							sfd_pkg::SUB_SPIN_UP: next_s.spin_up_go = 1'b1; // R17
							sfd_pkg::SUB_HIPWR_ON: next_s.set.high_power = 1'b1; // R18
							sfd_pkg::SUB_HIPWR_OFF: next_s.set.high_power = 1'b0; // R18
							sfd_pkg::SUB_AAM_ON: begin
								next_s.set.aam_en = 1'b1; // R19
								next_s.set.aam_level = s.lat_count;
							end
							sfd_pkg::SUB_AAM_OFF: next_s.set.aam_en = 1'b0; // R19
							sfd_pkg::SUB_LOOKAHEAD_OFF: next_s.set.look_ahead = 1'b0; // R20
							sfd_pkg::SUB_LOOKAHEAD_ON: next_s.set.look_ahead = 1'b1; // R20
							sfd_pkg::SUB_KEEP_SETTINGS: next_s.set.keep_settings = 1'b1; // R21
							sfd_pkg::SUB_REVERT_SETTINGS: next_s.set.keep_settings = 1'b0; // R21
							default: ;
						endcase
					end
				end
				next_s.st = sfd_pkg::ST_DONE;
			end
			sfd_pkg::ST_DONE: begin
				// Status is updated one cycle after the effect, in the same cycle that busy drops
				next_s.busy_flag = 1'b0; // R9 R23
				next_s.device_ready_flag = 1'b1; // R9
				next_s.data_request_flag = 1'b0; // R9
				next_s.df = fault; // R9
				next_s.st = sfd_pkg::ST_IDLE;
			end
			default: next_s.st = sfd_pkg::ST_IDLE;
		endcase

		// Soft reset from the control register; persistent settings survive it
		if (bus_req.wr && (bus_req.addr == sfd_pkg::OFF_CONTROL) && bus_req.wdata[sfd_pkg::BIT_CTRL_SRST]) begin
			next_s.st = sfd_pkg::ST_IDLE;
			next_s.busy_flag = 1'b0;
			next_s.err = 8'h00;
			next_s.device_ready_flag = 1'b1;
			if (!s.set.keep_settings) begin
				next_s.set = sfd_pkg::SETTINGS_DEFAULT; // R21
				next_s.set.puis_en = s.set.puis_en;
			end
		end

		// Set wins over the clear made by an accepted service
		if (release_req) begin
			next_s.service_request_flag = 1'b1; // R2
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s <= REGS_RESET; // R11
		end else begin
			s <= next_s;
		end
	end

	assign rd_data = s.rd_data;
	assign settings = s.set;
	assign service_go = s.service_go;
	assign spin_up_go = s.spin_up_go;

	// ==========================================================
	// Checks
	efh_accept_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R5
		(cmd_accept && bus_req.wdata == sfd_pkg::OP_SET_FEATURES) |=> s.busy_flag ##1 s.busy_flag ##1 !s.busy_flag)
		else $error("set-features did not hold busy for two cycles");
	other_drive_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R4
		(cmd_write && !s.busy_flag && s.devhead[sfd_pkg::BIT_DRIVE_SEL] != DEVICE_SELECT) |=> !s.busy_flag)
		else $error("command for other drive was accepted");
	done_status_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R9
		(s.st == sfd_pkg::ST_DONE) |=> (!s.busy_flag && s.device_ready_flag && !s.data_request_flag && s.df == $past(fault)))
		else $error("completion status wrong");
	err_summary_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R9
		(bus_req.rd && bus_req.addr == sfd_pkg::OFF_CMD_STAT) |=> rd_data[sfd_pkg::BIT_ERR] == ($past(s.err) != 8'h00))
		else $error("error summary mismatch");
	abort_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R7
		(s.st == sfd_pkg::ST_EXEC && s.lat_op == sfd_pkg::OP_SET_FEATURES && !sub_ok)
		|=> s.err[sfd_pkg::BIT_ABORT] ##1 (!s.busy_flag && s.err != 8'h00))
		else $error("unsupported subcommand not aborted");
	reserved_code_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R22
		(s.st == sfd_pkg::ST_EXEC && s.lat_op == sfd_pkg::OP_SET_FEATURES && s.lat_sub[7:4] == 4'hf)
		|=> s.err[sfd_pkg::BIT_ABORT])
		else $error("reserved subcommand not aborted");
	service_go_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R1
		(s.st == sfd_pkg::ST_EXEC && s.lat_op == sfd_pkg::OP_SERVICE && s.service_request_flag)
		|=> (service_go && $stable(s.err)))
		else $error("service did not resume serviced command");
	service_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R2
		(s.st == sfd_pkg::ST_EXEC && s.lat_op == sfd_pkg::OP_SERVICE && !s.service_request_flag)
		|=> (!service_go && s.err[sfd_pkg::BIT_ABORT]))
		else $error("service ran without a pending request");
	xfer_mode_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R12
		(s.st == sfd_pkg::ST_EXEC && s.lat_op == sfd_pkg::OP_SET_FEATURES &&
		s.lat_sub == sfd_pkg::SUB_XFER_MODE && !mode_valid(s.lat_count))
		|=> $stable(s.set.xfer_mode))
		else $error("invalid transfer mode was taken");
	latched_args_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R23
		cmd_accept |=> (s.lat_sub == $past(s.feat) && s.lat_count == $past(s.count)))
		else $error("arguments not sampled at command write");

	// Effect cycle of set-features; a soft reset write in that cycle would override the effect
	logic sf_exec;
	assign sf_exec = (s.st == sfd_pkg::ST_EXEC) && (s.lat_op == sfd_pkg::OP_SET_FEATURES) && !bus_req.wr;

	busy_state_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R23
		s.busy_flag == (s.st != sfd_pkg::ST_IDLE))
		else $error("busy flag and command state disagree");

	spin_go_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R17
		(sf_exec && s.lat_sub == sfd_pkg::SUB_SPIN_UP && !action_fail) |=> spin_up_go)
		else $error("spin-up request missing");

	go_pulse_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R1
		(service_go || spin_up_go) |=> !(service_go || spin_up_go))
		else $error("request pulse longer than one cycle");

	wcache_off_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R13
		(sf_exec && s.lat_sub == sfd_pkg::SUB_WCACHE_OFF && sub_ok && !action_fail)
		|=> !settings.write_cache)
		else $error("write cache not disabled");

	xfer_take_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R12
		(sf_exec && s.lat_sub == sfd_pkg::SUB_XFER_MODE && sub_ok && !action_fail)
		|=> settings.xfer_mode == s.lat_count)
		else $error("valid transfer mode not taken");

	apm_level_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R16
		(sf_exec && s.lat_sub == sfd_pkg::SUB_APM_ON && sub_ok && !action_fail)
		|=> (settings.apm_en && settings.apm_level == s.lat_count))
		else $error("power management level not taken");

	look_ahead_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R20
		(sf_exec && s.lat_sub == sfd_pkg::SUB_LOOKAHEAD_OFF && !action_fail) |=> !settings.look_ahead)
		else $error("read look-ahead not disabled");

	action_fail_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R8
		(sf_exec && action_fail) |=> s.err[sfd_pkg::BIT_ABORT])
		else $error("failed action not aborted");

	err_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R7
		(sf_exec && sub_ok && !action_fail) |=> s.err == 8'h00)
		else $error("error register not cleared on success");

	service_request_flag_set_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R2
		release_req |=> s.service_request_flag)
		else $error("service request flag not set");

	devhead_read_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R4
		(bus_req.rd && bus_req.addr == sfd_pkg::OFF_DEVHEAD) |=> rd_data == $past(s.devhead))
		else $error("drive select readback wrong");

	count_read_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R3
		(bus_req.rd && bus_req.addr == sfd_pkg::OFF_COUNT) |=> rd_data == $past(s.count))
		else $error("count readback wrong");

	rd_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R3
		!bus_req.rd |=> rd_data == 8'h00)
		else $error("read data outside its cycle");

	idle_settings_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R23
		(s.st == sfd_pkg::ST_IDLE && !bus_req.wr) |=> $stable(settings))
		else $error("settings changed with no command");

	keep_soft_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R21
		(bus_req.wr && bus_req.addr == sfd_pkg::OFF_CONTROL && bus_req.wdata[sfd_pkg::BIT_CTRL_SRST] &&
		s.set.keep_settings && s.st == sfd_pkg::ST_IDLE) |=> $stable(settings))
		else $error("kept settings lost on soft reset");
endmodule : sfd_decoder

//--- test/sfd_host_model.sv
/* Host adapter model: bus cycles and command issue on the task-file port.
   Assumes the decoder samples bus_req on the rising edge of clk_sys. */
module sfd_host_model (
	input wire logic clk_sys,
	input wire logic [7:0] rd_data,
	output sfd_pkg::sfd_bus_req_type bus_req
);
	timeunit 1ns;
	timeprecision 1ps;
	initial bus_req = '0;

	// ==========
	// Bus cycles
	task automatic put(input logic [3:0] a, input logic [7:0] d, input logic w);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: d, wr: w, rd: ~w};
		@(posedge clk_sys);
		// Released lines show the inverse so a stale value cannot pass
		bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask : put

	task automatic get(input logic [3:0] a, output logic [7:0] d);
		put(a, 8'h00, 1'b0);
		#1;
		d = rd_data;
	endtask : get

	// Back-to-back status reads so a short busy window is not missed
	task automatic poll(output logic [7:0] st, output logic busy);
		busy = 1'b0;
		st = 8'h00;
		@(posedge clk_sys);
		bus_req <= '{addr: sfd_pkg::OFF_CMD_STAT, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			if (i == 7) begin
				bus_req <= '{addr: 4'h8, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
			end
			#1;
			busy = busy | rd_data[7];
			st = rd_data;
		end
	endtask : poll

	task automatic command(input logic [7:0] op, output logic [7:0] st, output logic busy);
		logic [7:0] s;
		get(sfd_pkg::OFF_CMD_STAT, s);
		if (s[sfd_pkg::BIT_READY] === 1'b1 || op !== sfd_pkg::OP_SET_FEATURES) begin
			put(sfd_pkg::OFF_CMD_STAT, op, 1'b1);
		end
		poll(st, busy);
	endtask : command
endmodule : sfd_host_model

//--- test/test_service_and_set_features_decoder.sv
/* Self-checking bench for the service and set-features decoder.
   Assumes default parameters and the host model for all bus traffic. */
module test_service_and_set_features_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic release_req = 1'b0;
	logic fault = 1'b0;
	logic action_fail = 1'b0;
	sfd_pkg::sfd_bus_req_type bus_req;
	sfd_pkg::sfd_settings_type settings;
	logic [7:0] rd_data;
	logic [7:0] st;
	logic [7:0] v;
	logic busy_flag;
	logic service_go;
	logic spin_up_go;
	int n_mismatch = 0;
	int checked = 0;
	int n_service_request_flag = 0;
	int n_spin = 0;
	int cycles = 0;
	// Subcode, count argument, expected error byte
	logic [23:0] tab [32] = '{24'h020000, 24'h820000, 24'h034500, 24'h034604, 24'h030100, 24'h031004,
		24'h058000, 24'h050004, 24'h05ff04, 24'h850000, 24'h060000, 24'h070000, 24'h860000, 24'h0a0000,
		24'h8a0000, 24'h428000, 24'hc20000, 24'h550000, 24'haa0000, 24'h660000, 24'hcc0000, 24'h010004,
		24'h810004, 24'h950004, 24'h310004, 24'h090004, 24'h890004, 24'hf00004, 24'hff0004, 24'h040004,
		24'h5d0004, 24'h000004};

	initial forever #2 clk_sys = ~clk_sys;

	sfd_decoder u_dut (.clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req), .rd_data(rd_data),
		.release_req(release_req), .fault(fault), .action_fail(action_fail), .settings(settings),
		.service_go(service_go), .spin_up_go(spin_up_go));
	sfd_host_model u_host (.clk_sys(clk_sys), .rd_data(rd_data), .bus_req(bus_req));

	// ==========
	// Pulse counters and hang guard; negedge keeps clear of output updates
	always @(negedge clk_sys) begin
		cycles++;
		if (service_go === 1'b1) n_service_request_flag++;
		if (spin_up_go === 1'b1) n_spin++;
		if (cycles == 5000) begin
			n_mismatch++;
			final_report();
		end
	end

	// ==========
	// Shared tasks
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic final_report();
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	task automatic do_reset();
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
	endtask : do_reset

	task automatic sf(input logic [7:0] sub, arg, st_e, err_e);
		u_host.put(sfd_pkg::OFF_FEAT_ERR, sub, 1'b1);
		u_host.put(sfd_pkg::OFF_COUNT, arg, 1'b1);
		u_host.command(sfd_pkg::OP_SET_FEATURES, st, busy_flag);
		chk(64'(busy_flag), 64'h1);
		chk(64'(st), 64'(st_e));
		u_host.get(sfd_pkg::OFF_FEAT_ERR, v);
		chk(64'(v), 64'(err_e));
	endtask : sf

	// ==========
	// Scenarios
	task automatic t_defaults();
		chk(64'(settings), 64'(sfd_pkg::SETTINGS_DEFAULT));
		u_host.get(sfd_pkg::OFF_CMD_STAT, v);
		chk(64'(v), 64'h40);
		$display("defaults test done");
	endtask : t_defaults

	task automatic t_devsel();
		u_host.put(sfd_pkg::OFF_DEVHEAD, 8'h10, 1'b1);
		u_host.put(sfd_pkg::OFF_FEAT_ERR, sfd_pkg::SUB_WCACHE_OFF, 1'b1);
		u_host.command(sfd_pkg::OP_SET_FEATURES, st, busy_flag);
		chk(64'(busy_flag), 64'h0);
		chk(64'(settings.write_cache), 64'h1);
		u_host.get(sfd_pkg::OFF_DEVHEAD, v);
		chk(64'(v), 64'h10);
		u_host.put(sfd_pkg::OFF_DEVHEAD, 8'h00, 1'b1);
		$display("drive select test done");
	endtask : t_devsel

	task automatic t_service();
		int s0;
		@(posedge clk_sys);
		release_req <= 1'b1;
		@(posedge clk_sys);
		release_req <= 1'b0;
		u_host.get(sfd_pkg::OFF_CMD_STAT, v);
		chk(64'(v), 64'h50);
		u_host.put(sfd_pkg::OFF_COUNT, 8'h5a, 1'b1);
		s0 = n_service_request_flag;
		u_host.command(sfd_pkg::OP_SERVICE, st, busy_flag);
		chk(64'(st), 64'h40);
		chk(64'(n_service_request_flag - s0), 64'h1);
		u_host.get(sfd_pkg::OFF_COUNT, v);
		chk(64'(v), 64'h5a);
		// No pending release: refused with an abort and no resume pulse
		u_host.command(sfd_pkg::OP_SERVICE, st, busy_flag);
		chk(64'(st), 64'h41);
		chk(64'(n_service_request_flag - s0), 64'h1);
		$display("service test done");
	endtask : t_service

	task automatic t_table();
		logic [7:0] sub;
		logic [7:0] arg;
		logic [7:0] err;
		int s0;
		for (int i = 0; i < 32; i++) begin
			{sub, arg, err} = tab[i];
			s0 = n_spin;
			sf(sub, arg, {7'h20, |err}, err);
			if (err == 8'h00) begin
				case (sub)
					8'h02, 8'h82: chk(64'(settings.write_cache), 64'(sub == 8'h02));
					8'h03: chk(64'(settings.xfer_mode), 64'(arg));
					8'h05: chk(64'({settings.apm_en, settings.apm_level}), 64'({1'b1, arg}));
					8'h85: chk(64'(settings.apm_en), 64'h0);
					8'h06, 8'h86: chk(64'(settings.puis_en), 64'(sub == 8'h06));
					8'h07: chk(64'(n_spin - s0), 64'h1);
					8'h0a, 8'h8a: chk(64'(settings.high_power), 64'(sub == 8'h0a));
					8'h42, 8'hc2: chk(64'(settings.aam_en), 64'(sub == 8'h42));
					8'h55, 8'haa: chk(64'(settings.look_ahead), 64'(sub == 8'haa));
					8'h66, 8'hcc: chk(64'(settings.keep_settings), 64'(sub == 8'h66));
					default: ;
				endcase
			end
		end
		$display("subcommand table test done");
	endtask : t_table

	task automatic t_fault();
		@(posedge clk_sys);
		fault <= 1'b1;
		sf(sfd_pkg::SUB_WCACHE_ON, 8'h00, 8'h60, 8'h00);
		@(posedge clk_sys);
		fault <= 1'b0;
		action_fail <= 1'b1;
		sf(sfd_pkg::SUB_WCACHE_ON, 8'h00, 8'h41, 8'h04);
		@(posedge clk_sys);
		action_fail <= 1'b0;
		$display("fault test done");
	endtask : t_fault

	task automatic t_soft();
		sf(sfd_pkg::SUB_WCACHE_OFF, 8'h00, 8'h40, 8'h00);
		sf(sfd_pkg::SUB_KEEP_SETTINGS, 8'h00, 8'h40, 8'h00);
		u_host.put(sfd_pkg::OFF_CONTROL, 8'h04, 1'b1);
		u_host.get(sfd_pkg::OFF_CMD_STAT, v);
		chk(64'(v), 64'h40);
		chk(64'(settings.write_cache), 64'h0);
		sf(sfd_pkg::SUB_REVERT_SETTINGS, 8'h00, 8'h40, 8'h00);
		u_host.put(sfd_pkg::OFF_CONTROL, 8'h04, 1'b1);
		u_host.get(sfd_pkg::OFF_CMD_STAT, v);
		chk(64'(settings), 64'(sfd_pkg::SETTINGS_DEFAULT));
		$display("soft reset test done");
	endtask : t_soft

	task automatic t_rereset();
		do_reset();
		chk(64'(settings), 64'(sfd_pkg::SETTINGS_DEFAULT));
		$display("second reset test done");
	endtask : t_rereset

	initial begin
		do_reset();
		t_defaults();
		t_devsel();
		t_service();
		t_table();
		t_fault();
		t_soft();
		t_rereset();
		final_report();
	end
endmodule : test_service_and_set_features_decoder
